// ### rtl/scs_pkg.sv
// constants and types of the system clock source selector
package scs_pkg;
  // boot configuration word one fields
  localparam int OSC_SEL_LSB = 0;
  localparam int OSC_SEL_MSB = 2;
  localparam int PRI_MODE_LSB = 8;
  localparam int PRI_MODE_MSB = 9;
  localparam int CLK_OUT_BIT = 10;
  // boot configuration word two fields
  localparam int PLL_IDIV_LSB = 0;
  localparam int PLL_MULT_LSB = 4;
  localparam int PLL_ODIV_LSB = 16;
  // oscillator control register fields
  localparam int CTL_ODIV_LSB = 27;
  localparam int CTL_MULT_LSB = 16;
  localparam int CTL_LOCK_BIT = 5;
  localparam int CTL_SEL_LSB = 8;
  // oscillator select codes
  localparam logic [2:0] SEL_FRC_POST = 3'h7;
  localparam logic [2:0] SEL_FRC_DIV16 = 3'h6;
  localparam logic [2:0] SEL_LOW_POWER_RC_OSCILLATOR = 3'h5;
  localparam logic [2:0] SEL_SEC = 3'h4;
  localparam logic [2:0] SEL_PRI_PLL = 3'h3;
  localparam logic [2:0] SEL_PRI = 3'h2;
  localparam logic [2:0] SEL_FRC_PLL = 3'h1;
  localparam logic [2:0] SEL_FRC = 3'h0;
  localparam logic [2:0] SEL_ERASED = 3'h7;
  // primary mode codes
  localparam logic [1:0] PRI_OFF = 2'h3;
  localparam logic [1:0] PRI_HIGH_GAIN = 2'h2;
  localparam logic [1:0] PRI_MED_GAIN = 2'h1;
  localparam logic [1:0] PRI_EXT_CLK = 2'h0;
  // start-up timer, PLL lock timeout, synchroniser depth and erased boot word
  localparam int SUT_WIDTH = 10;
  localparam int SUT_CYCLES = 1024;
  localparam int PLL_LOCK_CYCLES = 2000;
  localparam int SYNC_STAGES = 3;
  localparam logic [31:0] BOOT_ERASED = 32'hffff_ffff;

  typedef struct packed {
    logic [2:0] sel;
    logic [1:0] pri_mode;
  } scs_src_t;

  typedef struct packed {
    logic use_pri;
    logic use_sec;
    logic use_pll;
    logic need_sut;
  } scs_route_t;

  typedef enum logic [1:0] {
    SCS_IDLE,
    SCS_WAIT,
    SCS_COUNT,
    SCS_DONE
  } scs_sut_state_t;
endpackage : scs_pkg

// ### rtl/scs_startup_timer.sv
// oscillator start-up timer counting synchronised oscillator edges
`timescale 1ns/1ps
module scs_startup_timer
  import scs_pkg::*;
#(
  parameter int WIDTH = SUT_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic restart,
  input wire logic needed,
  input wire logic level_ok,
  input wire logic osc_edge,
  output logic ready
);
  if (WIDTH < 2) begin : g_bad_width
    $error("scs_startup_timer: WIDTH too small");
  end

  scs_sut_state_t state_reg, state_next;
  logic [WIDTH-1:0] count_reg, count_next;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    if (restart) begin
      state_next = SCS_IDLE;
      count_next = '0;
    end else begin
      unique case (state_reg)
        SCS_IDLE: begin
          if (!needed) state_next = SCS_DONE;
          else state_next = SCS_WAIT;
        end
        SCS_WAIT: begin
          if (level_ok) state_next = SCS_COUNT;
        end
        SCS_COUNT: begin
          if (osc_edge) begin
            count_next = count_reg + 1'b1;
            if (&count_reg) state_next = SCS_DONE;
          end
        end
        SCS_DONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= SCS_IDLE;
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  assign ready = (state_reg == SCS_DONE);
endmodule : scs_startup_timer

// ### rtl/scs_clock_select.sv
// system clock source selection, start-up gating and pin control
//
// How it works
// - select code picks one of eight sources
// - primary mode picks crystal, resonator or external
// - erased configuration starts fast RC postscaled
// - boot chooses source, software may switch later
// - no scaling beyond configured divider and multiplier
// - crystal modes claim output pin for feedback
// - free output pin gives bus clock or I/O
// - external modes disable feedback, input is clock
// - each primary mode has a PLL variant
// - software sets PLL output divider bits 29:27
// - ten-bit timer counts 1024 oscillator cycles
// - timer waits for valid oscillator levels
// - timer reruns after power-on, brown-out, wake
// - timer applies to crystals and secondary oscillator
// - select bits 2:0, mode bits 9:8
// - lock clears on input change, sets later
// - reset copies PLL defaults into control register
// - PLL input divider comes only from boot
`timescale 1ns/1ps
module scs_clock_select
  import scs_pkg::*;
#(
  parameter int LOCK_CYCLES = PLL_LOCK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] boot_config_word_one,
  input wire logic [31:0] boot_config_word_two,
  input wire logic power_on_event,
  input wire logic brown_out_event,
  input wire logic wake_event,
  input wire logic switch_request,
  input wire logic [2:0] switch_select,
  input wire logic odiv_write,
  input wire logic [2:0] odiv_value,
  input wire logic mult_write,
  input wire logic [2:0] mult_value,
  input wire logic pll_locked,
  input wire logic primary_osc_in,
  input wire logic primary_level_ok,
  input wire logic secondary_osc_in,
  input wire logic secondary_level_ok,
  input wire logic peripheral_bus_clock,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic [31:0] oscillator_control_register,
  output scs_src_t active_source,
  output scs_route_t active_route,
  output logic switch_busy,
  output logic feedback_enable,
  output logic osc_out_o,
  output logic osc_out_oe,
  output logic osc_pin_free,
  output logic [2:0] pll_input_divider,
  output logic pll_lock_status
);
  if (LOCK_CYCLES < 1) begin : g_bad_lock
    $error("scs_clock_select: LOCK_CYCLES must be positive");
  end

  localparam int LW = $clog2(LOCK_CYCLES + 1);
  localparam int NUM_ASYNC = 5;

  // three-stage synchronisers for every input from outside the clock domain
  logic [NUM_ASYNC-1:0] async_in, async_level, async_rise;
  assign async_in = {pll_locked, secondary_level_ok, primary_level_ok, secondary_osc_in,
                     primary_osc_in};
  for (genvar g = 0; g < NUM_ASYNC; g++) begin : g_sync
    logic [SYNC_STAGES-1:0] sync_reg, sync_next;
    logic seen_reg, seen_next, agree;
    // a change counts once the last two stages agree
    assign agree = (sync_reg[SYNC_STAGES-2] == sync_reg[SYNC_STAGES-1]);
    always_comb begin
      sync_next = {sync_reg[SYNC_STAGES-2:0], async_in[g]};
      seen_next = agree ? sync_reg[SYNC_STAGES-1] : seen_reg;
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        sync_reg <= '0;
        seen_reg <= 1'b0;
      end else begin
        sync_reg <= sync_next;
        seen_reg <= seen_next;
      end
    end
    assign async_level[g] = seen_reg;
    assign async_rise[g] = agree && sync_reg[SYNC_STAGES-1] && !seen_reg;
  end
  logic pri_rise, sec_rise, pri_level_ok, sec_level_ok, locked_sync;
  assign pri_rise = async_rise[0];
  assign sec_rise = async_rise[1];
  assign pri_level_ok = async_level[2];
  assign sec_level_ok = async_level[3];
  assign locked_sync = async_level[4];

  // boot fields
  scs_src_t boot_src;
  always_comb begin
    boot_src.sel = boot_config_word_one[OSC_SEL_MSB:OSC_SEL_LSB];
    boot_src.pri_mode = boot_config_word_one[PRI_MODE_MSB:PRI_MODE_LSB];
  end
  assign pll_input_divider = boot_config_word_two[PLL_IDIV_LSB +: 3];

  function automatic scs_route_t route_of(input scs_src_t s);
    scs_route_t r;
    r = '0;
    unique case (s.sel)
      SEL_PRI_PLL: begin
        r.use_pri = 1'b1;
        r.use_pll = 1'b1;
      end
      SEL_PRI: r.use_pri = 1'b1;
      SEL_SEC: r.use_sec = 1'b1;
      SEL_FRC_PLL: r.use_pll = 1'b1;
      SEL_FRC_POST, SEL_FRC_DIV16, SEL_LOW_POWER_RC_OSCILLATOR, SEL_FRC: r = '0;
    endcase
    r.need_sut = r.use_sec || (r.use_pri && (s.pri_mode == PRI_HIGH_GAIN
                 || s.pri_mode == PRI_MED_GAIN));
    return r;
  endfunction

  // source state: active and pending
  scs_src_t active_reg, active_next, pend_reg, pend_next;
  logic pend_valid_reg, pend_valid_next, boot_load_reg, boot_load_next;
  logic [2:0] odiv_reg, odiv_next, mult_reg, mult_next;
  logic restart;
  logic sut_ready;
  scs_route_t pend_route;

  assign restart = power_on_event || brown_out_event || wake_event || boot_load_reg;
  assign pend_route = route_of(pend_valid_reg ? pend_reg : active_reg);

  always_comb begin
    active_next = active_reg;
    pend_next = pend_reg;
    pend_valid_next = pend_valid_reg;
    boot_load_next = 1'b0;
    odiv_next = odiv_reg;
    mult_next = mult_reg;
    if (boot_load_reg) begin
      active_next = boot_src;
      odiv_next = boot_config_word_two[PLL_ODIV_LSB +: 3];
      mult_next = boot_config_word_two[PLL_MULT_LSB +: 3];
      pend_valid_next = 1'b0;
    end else begin
      if (switch_request) begin
        pend_next.sel = switch_select;
        pend_next.pri_mode = boot_src.pri_mode;
        pend_valid_next = 1'b1;
      end else if (pend_valid_reg && sut_ready) begin
        active_next = pend_reg;
        pend_valid_next = 1'b0;
      end
      if (odiv_write) odiv_next = odiv_value;
      if (mult_write) mult_next = mult_value;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_reg <= '{sel: SEL_ERASED, pri_mode: PRI_OFF};
      pend_reg <= '{sel: SEL_ERASED, pri_mode: PRI_OFF};
      pend_valid_reg <= 1'b0;
      boot_load_reg <= 1'b1;
      odiv_reg <= '0;
      mult_reg <= '0;
    end else begin
      active_reg <= active_next;
      pend_reg <= pend_next;
      pend_valid_reg <= pend_valid_next;
      boot_load_reg <= boot_load_next;
      odiv_reg <= odiv_next;
      mult_reg <= mult_next;
    end
  end

  // start-up timer for the source being brought up
  logic sut_restart;
  assign sut_restart = restart || switch_request;
  scs_startup_timer #(
    .WIDTH(SUT_WIDTH)
  ) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .restart(sut_restart),
    .needed(pend_route.need_sut),
    .level_ok(pend_route.use_sec ? sec_level_ok : pri_level_ok),
    .osc_edge(pend_route.use_sec ? sec_rise : pri_rise),
    .ready(sut_ready)
  );

  // PLL lock status
  logic lock_reg, lock_next;
  logic [LW-1:0] lock_cnt_reg, lock_cnt_next;
  logic pll_in_change;
  assign pll_in_change = restart || (pend_valid_reg && sut_ready && pend_route.use_pll
                         && (pend_reg != active_reg));
  always_comb begin
    lock_next = lock_reg;
    lock_cnt_next = lock_cnt_reg;
    if (pll_in_change) begin
      lock_next = 1'b0;
      lock_cnt_next = '0;
    end else if (!lock_reg) begin
      if (locked_sync || lock_cnt_reg == LW'(LOCK_CYCLES - 1)) lock_next = 1'b1;
      else lock_cnt_next = lock_cnt_reg + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_reg <= 1'b0;
      lock_cnt_reg <= '0;
    end else begin
      lock_reg <= lock_next;
      lock_cnt_reg <= lock_cnt_next;
    end
  end

  // pin control and outputs
  scs_route_t act_route;
  logic crystal;
  assign act_route = route_of(active_reg);
  assign crystal = act_route.use_pri && (active_reg.pri_mode == PRI_HIGH_GAIN
                   || active_reg.pri_mode == PRI_MED_GAIN);
  assign feedback_enable = crystal;
  assign osc_pin_free = !crystal;
  always_comb begin
    osc_out_o = 1'b0;
    osc_out_oe = 1'b0;
    if (!crystal) begin
      if (boot_config_word_one[CLK_OUT_BIT]) begin
        osc_out_o = peripheral_bus_clock;
        osc_out_oe = 1'b1;
      end else begin
        osc_out_o = gpio_out;
        osc_out_oe = gpio_oe;
      end
    end
  end

  assign active_source = active_reg;
  assign active_route = act_route;
  assign switch_busy = pend_valid_reg;
  assign pll_lock_status = lock_reg;
  always_comb begin
    oscillator_control_register = '0;
    oscillator_control_register[CTL_ODIV_LSB +: 3] = odiv_reg;
    oscillator_control_register[CTL_MULT_LSB +: 3] = mult_reg;
    oscillator_control_register[CTL_SEL_LSB +: 3] = active_reg.sel;
    oscillator_control_register[CTL_LOCK_BIT] = lock_reg;
  end
endmodule : scs_clock_select

// ### tb/scs_clock_select_monitor.sv
// port assertions for the clock source selector
`timescale 1ns/1ps
module scs_clock_select_monitor
  import scs_pkg::*;
#(
  parameter int LOCK_CYCLES = PLL_LOCK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] boot_config_word_one,
  input wire logic [31:0] boot_config_word_two,
  input wire logic wake_event,
  input wire logic switch_request,
  input wire logic odiv_write,
  input wire logic [2:0] odiv_value,
  input wire logic peripheral_bus_clock,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic [31:0] oscillator_control_register,
  input wire scs_src_t active_source,
  input wire logic switch_busy,
  input wire logic feedback_enable,
  input wire logic osc_out_o,
  input wire logic osc_out_oe,
  input wire logic osc_pin_free,
  input wire logic [2:0] pll_input_divider,
  input wire logic pll_lock_status
);
  localparam int LOCK_MAX = LOCK_CYCLES + 4;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  pin_claim_a: assert property (!osc_pin_free |-> !osc_out_oe)
    else $error("claimed pin is driven");
  feedback_mode_a: assert property (feedback_enable == !osc_pin_free)
    else $error("feedback and pin use disagree");
  clock_out_a: assert property (
    $past(reset_n) && osc_pin_free && boot_config_word_one[CLK_OUT_BIT]
    |-> osc_out_oe && osc_out_o == peripheral_bus_clock)
    else $error("bus clock missing on free pin");
  gpio_out_a: assert property (
    $past(reset_n) && osc_pin_free && !boot_config_word_one[CLK_OUT_BIT]
    |-> osc_out_o == gpio_out && osc_out_oe == gpio_oe)
    else $error("gpio missing on free pin");
  input_div_a: assert property ($past(reset_n) |-> pll_input_divider == boot_config_word_two[2:0])
    else $error("input divider not from boot");
  out_div_a: assert property (
    odiv_write |=> oscillator_control_register[29:27] == $past(odiv_value))
    else $error("output divider write lost");
  busy_start_a: assert property (switch_request |=> switch_busy)
    else $error("switch not pending");
  source_change_a: assert property (
    $past(reset_n, 2) && $changed(active_source) |-> $fell(switch_busy))
    else $error("source changed outside a switch");
  lock_drop_a: assert property ($rose(wake_event) |-> ##[1:2] !pll_lock_status)
    else $error("lock kept over restart");
  lock_set_a: assert property ($fell(pll_lock_status) |-> ##[1:LOCK_MAX] pll_lock_status)
    else $error("lock not set after timeout");
  sel_field_a: assert property (oscillator_control_register[10:8] == active_source.sel)
    else $error("select field differs from source");
endmodule : scs_clock_select_monitor

bind scs_clock_select scs_clock_select_monitor #(
  .LOCK_CYCLES(LOCK_CYCLES)
) scs_clock_select_monitor_inst (
  .clk(clk),
  .reset_n(reset_n),
  .boot_config_word_one(boot_config_word_one),
  .boot_config_word_two(boot_config_word_two),
  .wake_event(wake_event),
  .switch_request(switch_request),
  .odiv_write(odiv_write),
  .odiv_value(odiv_value),
  .peripheral_bus_clock(peripheral_bus_clock),
  .gpio_out(gpio_out),
  .gpio_oe(gpio_oe),
  .oscillator_control_register(oscillator_control_register),
  .active_source(active_source),
  .switch_busy(switch_busy),
  .feedback_enable(feedback_enable),
  .osc_out_o(osc_out_o),
  .osc_out_oe(osc_out_oe),
  .osc_pin_free(osc_pin_free),
  .pll_input_divider(pll_input_divider),
  .pll_lock_status(pll_lock_status)
);

// ### tb/scs_osc_model.sv
// oscillator whose edges appear before its amplitude is valid
`timescale 1ns/1ps
module scs_osc_model #(
  parameter int SETTLE_NS = 2000
) (
  input wire logic run,
  output logic osc,
  output logic level_ok
);
  initial osc = 1'b0;
  always #100 if (run) osc = ~osc;
  always begin
    level_ok = 1'b0;
    wait (run);
    #(SETTLE_NS);
    // amplitude turns valid on an oscillator edge, clear of the sampling clock
    @(posedge osc) level_ok = run;
    wait (!run);
  end
endmodule : scs_osc_model

// ### tb/scs_clock_select_test.sv
// self-checking bench for the clock source selector
`timescale 1ns/1ps
module scs_clock_select_test;
  import scs_pkg::*;
  logic clk, reset_n, power_on_event, brown_out_event, wake_event, switch_request;
  logic odiv_write, mult_write, pll_locked, primary_osc_in, primary_level_ok;
  logic secondary_osc_in, secondary_level_ok, peripheral_bus_clock, gpio_out, gpio_oe;
  logic [2:0] switch_select, odiv_value, mult_value, pll_input_divider;
  logic [31:0] boot_config_word_one, boot_config_word_two, oscillator_control_register;
  scs_src_t active_source;
  scs_route_t active_route;
  logic switch_busy, feedback_enable, osc_out_o, osc_out_oe, osc_pin_free, pll_lock_status;
  logic pri_run, sec_run;
  int err_count, compares, n;
  localparam logic [31:0] CFG2 = 32'hfffa_ffd9;
  localparam logic [2:0] FAST [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};

  scs_clock_select #(
    .LOCK_CYCLES(8)
  ) scs_clock_select_inst (
    .clk(clk),
    .reset_n(reset_n),
    .boot_config_word_one(boot_config_word_one),
    .boot_config_word_two(boot_config_word_two),
    .power_on_event(power_on_event),
    .brown_out_event(brown_out_event),
    .wake_event(wake_event),
    .switch_request(switch_request),
    .switch_select(switch_select),
    .odiv_write(odiv_write),
    .odiv_value(odiv_value),
    .mult_write(mult_write),
    .mult_value(mult_value),
    .pll_locked(pll_locked),
    .primary_osc_in(primary_osc_in),
    .primary_level_ok(primary_level_ok),
    .secondary_osc_in(secondary_osc_in),
    .secondary_level_ok(secondary_level_ok),
    .peripheral_bus_clock(peripheral_bus_clock),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe),
    .oscillator_control_register(oscillator_control_register),
    .active_source(active_source),
    .active_route(active_route),
    .switch_busy(switch_busy),
    .feedback_enable(feedback_enable),
    .osc_out_o(osc_out_o),
    .osc_out_oe(osc_out_oe),
    .osc_pin_free(osc_pin_free),
    .pll_input_divider(pll_input_divider),
    .pll_lock_status(pll_lock_status)
  );
  scs_osc_model pri_osc_inst (.run(pri_run), .osc(primary_osc_in), .level_ok(primary_level_ok));
  scs_osc_model sec_osc_inst (.run(sec_run), .osc(secondary_osc_in), .level_ok(secondary_level_ok));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) peripheral_bus_clock <= ~peripheral_bus_clock;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic do_reset(input logic [31:0] w1);
    reset_n <= 1'b0;
    boot_config_word_one <= w1;
    boot_config_word_two <= CFG2;
    repeat (4) @(posedge clk);
    check("reset src", active_source, {SEL_ERASED, PRI_OFF});
    check("reset lock", pll_lock_status, 1'b0);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic switch_to(input logic [2:0] s);
    switch_select <= s;
    switch_request <= 1'b1;
    @(posedge clk);
    switch_request <= 1'b0;
    n = 0;
    @(posedge clk);
    while (switch_busy === 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    check("new src", active_source.sel, s);
  endtask : switch_to

  task automatic pulse_wake(input logic brown);
    if (brown) brown_out_event <= 1'b1;
    else wake_event <= 1'b1;
    @(posedge clk);
    {brown_out_event, wake_event} <= 2'h0;
    repeat (20) @(posedge clk);
  endtask : pulse_wake

  task automatic t_erased;
    do_reset(BOOT_ERASED);
    check("boot src", active_source, {SEL_ERASED, PRI_OFF});
    check("idiv", pll_input_divider, 3'h1);
    check("odiv", oscillator_control_register[29:27], 3'h2);
    check("mult", oscillator_control_register[18:16], 3'h5);
    foreach (FAST[i]) begin
      switch_to(FAST[i]);
      check("fast span", n < 20, 1'b1);
    end
    odiv_write <= 1'b1;
    odiv_value <= 3'h5;
    @(posedge clk);
    odiv_write <= 1'b0;
    mult_write <= 1'b1;
    mult_value <= 3'h6;
    @(posedge clk);
    mult_write <= 1'b0;
    @(posedge clk);
    check("odiv w", oscillator_control_register[29:27], 3'h5);
    check("mult w", oscillator_control_register[18:16], 3'h6);
    $display("erased boot, fast switches and writes done");
  endtask : t_erased

  task automatic t_secondary;
    sec_run <= 1'b1;
    switch_to(SEL_SEC);
    check("sec span", n inside {[8250:8300]}, 1'b1);
    pulse_wake(1'b0);
    check("wake src", active_source.sel, SEL_SEC);
    $display("secondary start-up done");
  endtask : t_secondary

  task automatic t_crystal;
    do_reset(32'hffff_faf8);
    pri_run <= 1'b1;
    switch_to(SEL_PRI);
    check("pri span", n inside {[8250:8300]}, 1'b1);
    check("mode", active_source.pri_mode, PRI_HIGH_GAIN);
    check("fbk", {feedback_enable, osc_pin_free, osc_out_oe}, 3'h4);
    pulse_wake(1'b1);
    check("bor src", active_source.sel, SEL_PRI);
    $display("crystal start-up done");
  endtask : t_crystal

  task automatic t_external;
    do_reset(32'hffff_f8fb);
    gpio_out <= 1'b1;
    gpio_oe <= 1'b1;
    repeat (2) @(posedge clk);
    check("ext src", active_source, {SEL_PRI_PLL, PRI_EXT_CLK});
    check("ext pin", {feedback_enable, osc_pin_free, osc_out_o}, 3'h3);
    check("pll", active_route.use_pll, 1'b1);
    switch_to(SEL_PRI);
    check("ext span", n < 20, 1'b1);
    check("no pll", active_route.use_pll, 1'b0);
    pll_locked <= 1'b1;
    repeat (5) @(posedge clk);
    switch_to(SEL_PRI_PLL);
    check("lock drop", pll_lock_status, 1'b0);
    @(posedge clk);
    check("lock set", pll_lock_status, 1'b1);
    $display("external clock done");
  endtask : t_external

  initial begin
    reset_n = 1'b0;
    {power_on_event, brown_out_event, wake_event, switch_request, odiv_write} = '0;
    {mult_write, pll_locked, gpio_out, gpio_oe, pri_run, sec_run} = '0;
    {switch_select, odiv_value, mult_value} = '0;
    peripheral_bus_clock = 1'b0;
    boot_config_word_one = BOOT_ERASED;
    boot_config_word_two = CFG2;
    err_count = 0;
    compares = 0;
    t_erased();
    t_secondary();
    t_crystal();
    t_external();
    test_done();
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule : scs_clock_select_test
